// ---- stp_cfg.svh ----
// What this block does
// - Sample mode select and data in on rising test clock
// - Data out changes only on falling test clock
// - Data out floats unless shifting
// - Output disable arises only with test reset low, where data out already floats
// - Test reset low: functional mode, scan ignored
// - Line A is scan-directed emulator interrupt
// - Line B is scan-directed emulator interrupt
// - Test reset low: line A high with line B low raises outputs_disabled, which gates no output
`ifndef STP_CFG_SVH
`define STP_CFG_SVH
`define STP_IR_WIDTH 4
`define STP_IR_RESET 4'h1
`define STP_IR_BYPASS 4'hF
`define STP_IR_EMUCTL 4'h8
`define STP_EMU_BITS 4
`endif

// ---- stp_pkg.sv ----
package stp_pkg;
    typedef enum logic [15:0] {
        STP_RESET = 16'h0001, STP_IDLE = 16'h0002, STP_SEL_DR = 16'h0004,
        STP_CAP_DR = 16'h0008, STP_SH_DR = 16'h0010, STP_EX1_DR = 16'h0020,
        STP_PAU_DR = 16'h0040, STP_EX2_DR = 16'h0080, STP_UPD_DR = 16'h0100,
        STP_SEL_IR = 16'h0200, STP_CAP_IR = 16'h0400, STP_SH_IR = 16'h0800,
        STP_EX1_IR = 16'h1000, STP_PAU_IR = 16'h2000, STP_EX2_IR = 16'h4000,
        STP_UPD_IR = 16'h8000
    } stp_state_t;
endpackage

// ---- stp_scan_port.sv ----
`timescale 1ns/1ps
`include "stp_cfg.svh"
module stp_scan_port
    import stp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst,
    output logic tdo_o,
    output logic tdo_oe,
    input wire logic emu_a_i,
    output logic emu_a_o,
    output logic emu_a_oe,
    input wire logic emu_b_i,
    output logic emu_b_o,
    output logic emu_b_oe,
    input wire logic emu_irq_out_a,
    input wire logic emu_irq_out_b,
    output logic emu_irq_in_a,
    output logic emu_irq_in_b,
    output logic scan_mode,
    output logic outputs_disabled
);
    // ----------------------------------------
    // Test clock domain
    // ----------------------------------------
    stp_state_t state;
    stp_state_t next_state;
    logic [`STP_IR_WIDTH-1:0] ir_shift;
    logic [`STP_IR_WIDTH-1:0] ir;
    logic [`STP_EMU_BITS-1:0] emu_shift;
    logic [`STP_EMU_BITS-1:0] emu_cfg;
    logic bypass;
    logic shifting;
    logic tdo_bit;
    logic cfg_tgl;

    // Either shift state of the two register paths
    function automatic logic stp_in_shift(input stp_state_t s);
        return (s == STP_SH_DR) || (s == STP_SH_IR);
    endfunction

    always_comb
    begin
        case (state)
            STP_RESET: next_state = tms ? STP_RESET : STP_IDLE;
            STP_IDLE: next_state = tms ? STP_SEL_DR : STP_IDLE;
            STP_SEL_DR: next_state = tms ? STP_SEL_IR : STP_CAP_DR;
            STP_CAP_DR: next_state = tms ? STP_EX1_DR : STP_SH_DR;
            STP_SH_DR: next_state = tms ? STP_EX1_DR : STP_SH_DR;
            STP_EX1_DR: next_state = tms ? STP_UPD_DR : STP_PAU_DR;
            STP_PAU_DR: next_state = tms ? STP_EX2_DR : STP_PAU_DR;
            STP_EX2_DR: next_state = tms ? STP_UPD_DR : STP_SH_DR;
            STP_UPD_DR: next_state = tms ? STP_SEL_DR : STP_IDLE;
            STP_SEL_IR: next_state = tms ? STP_RESET : STP_CAP_IR;
            STP_CAP_IR: next_state = tms ? STP_EX1_IR : STP_SH_IR;
            STP_SH_IR: next_state = tms ? STP_EX1_IR : STP_SH_IR;
            STP_EX1_IR: next_state = tms ? STP_UPD_IR : STP_PAU_IR;
            STP_PAU_IR: next_state = tms ? STP_EX2_IR : STP_PAU_IR;
            STP_EX2_IR: next_state = tms ? STP_UPD_IR : STP_SH_IR;
            STP_UPD_IR: next_state = tms ? STP_SEL_DR : STP_IDLE;
            default: next_state = STP_RESET;
        endcase
    end

    // Test reset low holds controller in reset, async constant only
    always_ff @(posedge tck or negedge trst)
    begin
        if (!trst)
            state <= STP_RESET;
        else
            state <= next_state;
    end

    always_ff @(posedge tck or negedge trst)
    begin
        if (!trst)
        begin
            ir_shift <= `STP_IR_RESET;
            ir <= `STP_IR_RESET;
        end
        else
        begin
            if (state == STP_CAP_IR)
                ir_shift <= `STP_IR_RESET;
            else if (state == STP_SH_IR)
                ir_shift <= {tdi, ir_shift[`STP_IR_WIDTH-1:1]};
            if (state == STP_RESET)
                ir <= `STP_IR_RESET;
            else if (state == STP_UPD_IR)
                ir <= ir_shift;
        end
    end

    // Data registers: bypass and emulation pin direction/value control
    always_ff @(posedge tck or negedge trst)
    begin
        if (!trst)
        begin
            bypass <= 1'b0;
            emu_shift <= '0;
            emu_cfg <= '0;
        end
        else
        begin
            if (state == STP_CAP_DR)
            begin
                bypass <= 1'b0;
                emu_shift <= emu_cfg;
            end
            else if (state == STP_SH_DR)
            begin
                bypass <= tdi;
                emu_shift <= {tdi, emu_shift[`STP_EMU_BITS-1:1]};
            end
            if (state == STP_RESET)
                emu_cfg <= '0;
            else if (state == STP_UPD_DR && ir == `STP_IR_EMUCTL)
                emu_cfg <= emu_shift;
        end
    end

    // Toggle marks each config change for the system clock side
    always_ff @(posedge tck or negedge trst)
    begin
        if (!trst)
            cfg_tgl <= 1'b0;
        else if (state == STP_UPD_DR && ir == `STP_IR_EMUCTL)
            cfg_tgl <= ~cfg_tgl;
        else if (state == STP_RESET && emu_cfg != '0)
            cfg_tgl <= ~cfg_tgl;
    end

    always_comb
    begin
        shifting = stp_in_shift(state);
        if (state == STP_SH_IR)
            tdo_bit = ir_shift[0];
        else if (ir == `STP_IR_EMUCTL)
            tdo_bit = emu_shift[0];
        else
            tdo_bit = bypass;
    end

    // Falling edge output stage
    always_ff @(negedge tck or negedge trst)
    begin
        if (!trst)
        begin
            tdo_o <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else
        begin
            tdo_o <= tdo_bit;
            tdo_oe <= shifting;
        end
    end

    // ----------------------------------------
    // System clock domain
    // ----------------------------------------
    logic [1:0] trst_sync;
    logic [1:0] emu_a_sync;
    logic [1:0] emu_b_sync;
    logic [2:0] tgl_sync;
    logic [`STP_EMU_BITS-1:0] cfg_clk;
    logic off_cond;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            trst_sync <= 2'h0;
            emu_a_sync <= 2'h3;
            emu_b_sync <= 2'h3;
            tgl_sync <= 3'h0;
        end
        else
        begin
            trst_sync <= {trst_sync[0], trst};
            emu_a_sync <= {emu_a_sync[0], emu_a_i};
            emu_b_sync <= {emu_b_sync[0], emu_b_i};
            tgl_sync <= {tgl_sync[1:0], cfg_tgl};
        end
    end

    // Config word is steady for many system clocks after its toggle
    always_ff @(posedge clk)
    begin
        if (rst)
            cfg_clk <= '0;
        else if (!trst_sync[1])
            cfg_clk <= '0;
        else if (tgl_sync[2] != tgl_sync[1])
            cfg_clk <= emu_cfg;
    end

    assign off_cond = !trst_sync[1] && emu_a_sync[1] && !emu_b_sync[1];

    // Mode and output disable status
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scan_mode <= 1'b0;
            outputs_disabled <= 1'b0;
        end
        else
        begin
            scan_mode <= trst_sync[1];
            outputs_disabled <= off_cond;
        end
    end

    // Interrupts arriving from the emulator
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            emu_irq_in_a <= 1'b0;
            emu_irq_in_b <= 1'b0;
        end
        else
        begin
            emu_irq_in_a <= trst_sync[1] && !cfg_clk[0] && emu_a_sync[1];
            emu_irq_in_b <= trst_sync[1] && !cfg_clk[1] && emu_b_sync[1];
        end
    end

    // Pin drive towards the emulator
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            emu_a_o <= 1'b0;
            emu_a_oe <= 1'b0;
            emu_b_o <= 1'b0;
            emu_b_oe <= 1'b0;
        end
        else
        begin
            emu_a_o <= emu_irq_out_a || cfg_clk[2];
            emu_b_o <= emu_irq_out_b || cfg_clk[3];
            emu_a_oe <= trst_sync[1] && cfg_clk[0];
            emu_b_oe <= trst_sync[1] && cfg_clk[1];
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_enter_shift;
        state == STP_CAP_DR ##1 state == STP_SH_DR;
    endsequence

    sequence s_cfg_mark;
        (tgl_sync[2] != tgl_sync[1]) && trst_sync[1];
    endsequence

    a_tdo_float_idle: assert property (@(negedge tck) disable iff (!trst)
        !shifting |=> !tdo_oe) else $error("tdo driven outside shift");
    a_tdo_on_shift: assert property (@(negedge tck) disable iff (!trst)
        shifting |=> tdo_oe && tdo_o == $past(tdo_bit)) else $error("tdo not shifted");
    a_tap_reset_5: assert property (@(posedge tck) disable iff (!trst)
        tms [*5] |=> state == STP_RESET) else $error("five tms high not reset");
    a_shift_dr_seq: assert property (@(posedge tck) disable iff (!trst)
        (s_enter_shift ##0 tms) |=> state == STP_EX1_DR) else $error("bad shift exit");
    a_ir_update: assert property (@(posedge tck) disable iff (!trst)
        state == STP_UPD_IR |=> ir == $past(ir_shift)) else $error("ir not updated");
    a_cfg_capture: assert property (@(posedge clk) disable iff (rst)
        s_cfg_mark |=> cfg_clk == $past(emu_cfg)) else $error("config not taken");
    a_oe_in_scan: assert property (@(posedge clk) disable iff (rst)
        (emu_a_oe || emu_b_oe) |-> scan_mode) else $error("line driven outside scan");
    a_off_follows: assert property (@(posedge clk) disable iff (rst)
        off_cond |=> outputs_disabled) else $error("output disable missed");
    a_off_needs_trst: assert property (@(posedge clk) disable iff (rst)
        outputs_disabled |-> !scan_mode) else $error("disable while scanning");
    a_emu_a_idle: assert property (@(posedge clk) disable iff (rst)
        !$past(trst_sync[1]) |-> !emu_a_oe) else $error("line a driven in functional");
    a_emu_b_idle: assert property (@(posedge clk) disable iff (rst)
        !$past(trst_sync[1]) |-> !emu_b_oe) else $error("line b driven in functional");
endmodule

// ---- stp_ctl_model.sv ----
`timescale 1ns/1ps
module stp_ctl_model
(
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst,
    input wire logic tdo_o,
    input wire logic tdo_oe
);
    logic got;
    // --------------------
    // Free-running test clock
    // --------------------
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst = 1'b0;
        #7;
        forever #80 tck = ~tck;
    end
    task hold(input logic r);
        trst = r;
    endtask
    // Pins move after the fall, data out taken at the rise
    task step(input logic m, input logic d);
        @(negedge tck);
        #2;
        tms = m;
        tdi = d;
        @(posedge tck);
        got = tdo_oe ? tdo_o : 1'bz;
    endtask
    task seq(input logic [7:0] ms, input int n);
        for (int i = 0; i < n; i++)
            step(ms[i], 1'b0);
    endtask
    task load_ir(input logic [3:0] v);
        seq(8'h03, 4);
        for (int i = 0; i < 4; i++)
            step(i == 3, v[i]);
        seq(8'h01, 2);
    endtask
    task shift_dr(input logic [3:0] v, output logic [3:0] q);
        seq(8'h01, 3);
        for (int i = 0; i < 4; i++)
        begin
            step(i == 3, v[i]);
            q[i] = got;
        end
        seq(8'h01, 2);
    endtask
endmodule

// ---- scan_test_emulation_port_tb.sv ----
`timescale 1ns/1ps
module scan_test_emulation_port_tb;
    logic clk, rst, emu_a_i, emu_b_i, irq_a, irq_b;
    logic tck, tms, tdi, trst, tdo_o, tdo_oe, a_oe, b_oe, in_a, in_b, smode, off;
    logic [3:0] q;
    logic a_o, b_o;
    int n_errors = 0;
    int comparisons = 0;
    stp_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .trst(trst), .tdo_o(tdo_o),
        .tdo_oe(tdo_oe));
    stp_scan_port dut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst(trst),
        .tdo_o(tdo_o), .tdo_oe(tdo_oe), .emu_a_i(emu_a_i), .emu_a_o(a_o), .emu_a_oe(a_oe),
        .emu_b_i(emu_b_i), .emu_b_o(b_o), .emu_b_oe(b_oe), .emu_irq_out_a(irq_a),
        .emu_irq_out_b(irq_b), .emu_irq_in_a(in_a), .emu_irq_in_b(in_b),
        .scan_mode(smode), .outputs_disabled(off));
    // --------------------
    // Helpers
    // --------------------
    task w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input logic g, input logic e, input string m);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task chk4(input logic [3:0] g, input logic [3:0] e, input string m);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task end_of_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // --------------------
    // Scenarios
    // --------------------
    task t_functional;
        ctl.seq(8'h5A, 8);
        w(4);
        chk(smode, 1'b0, "scan mode");
        chk(tdo_oe, 1'b0, "data out driven");
        $display("functional done");
    endtask
    // Disable used only as a test condition here
    task t_off;
        emu_a_i = 1'b1;
        w(4);
        chk(off, 1'b1, "no disable");
        chk(tdo_oe, 1'b0, "data out driven");
        emu_b_i = 1'b1;
        w(4);
        chk(off, 1'b0, "disable with b high");
        emu_a_i = 1'b0;
        emu_b_i = 1'b0;
        w(4);
        chk(off, 1'b0, "disable with a low");
        $display("off done");
    endtask
    task t_scan;
        ctl.hold(1'b1);
        emu_a_i = 1'b1;
        w(4);
        chk(smode, 1'b1, "no scan mode");
        chk(off, 1'b0, "disable in scan");
        chk(in_a, 1'b1, "line a irq");
        chk(in_b, 1'b0, "line b irq");
        ctl.seq(8'h1F, 6);
        ctl.load_ir(4'hF);
        ctl.shift_dr(4'hD, q);
        chk4(q, 4'hA, "bypass data");
        ctl.load_ir(4'h3);
        ctl.shift_dr(4'h5, q);
        chk4(q, 4'hA, "other code");
        chk(tdo_oe, 1'b0, "data out in idle");
        ctl.load_ir(4'h8);
        ctl.shift_dr(4'h3, q);
        chk4(q, 4'h0, "config after reset");
        w(4);
        chk(a_oe, 1'b1, "line a dir");
        chk(b_oe, 1'b1, "line b dir");
        chk(in_a, 1'b0, "line a irq while driving");
        irq_a = 1'b1;
        w(4);
        chk(a_o, 1'b1, "line a irq out");
        chk(b_o, 1'b0, "line b irq out");
        ctl.shift_dr(4'h3, q);
        chk4(q, 4'h3, "config readback");
        w(1);
        irq_a = 1'b0;
        ctl.hold(1'b0);
        w(4);
        chk(a_oe, 1'b0, "dir after test reset");
        chk(b_oe, 1'b0, "line b after test reset");
        $display("scan done");
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        #200000;
        n_errors++;
        end_of_test;
    end
    initial
    begin
        rst = 1'b1;
        emu_a_i = 1'b0;
        emu_b_i = 1'b0;
        irq_a = 1'b0;
        irq_b = 1'b0;
        w(4);
        rst = 1'b0;
        t_functional;
        t_off;
        t_scan;
        end_of_test;
    end
endmodule
